// file: logic/rtcs_regs.sv
// Overview of operation
// - oscillator-disable bit stops oscillator only on backup supply
// - stopped oscillator freezes divider, schedule and temperature
// - on backup, wave shows only if backup enable set and select 0
// - writing convert starts a conversion only when none is running
// - convert reads 1 until done, then convert and busy clear together
// - busy untouched for about 2 ms after a user conversion request
// - user conversions leave the 64 s periodic schedule alone
// - rate bits pick 1 Hz, 1.024, 4.096 or 8.192 kHz; reset to 11
// - select 0 gives square wave, select 1 gives alarm interrupt
// - alarm match always sets its flag
// - flag drives interrupt only with its enable and select set
// - osc-stopped flag sets on any stop, held until written 0
// - 32 kHz output enable drives pin while running, else hi-Z
// - busy rises with sensor conversion, clears at idle
// - alarm flags cleared only by writing 0
// - aging trim is two's complement, one step per small capacitor
// - trim applied on changed periodic result and every user conversion
// - temperature in two read-only bytes, fraction in bits 7:6
// - temperature is ten-bit two's complement, quarter degrees
// - conversion at power-up then every 64 s, result stored each time
`timescale 1ns/100ps
`default_nettype none
module rtcs_regs #(
   parameter int HOLD_CYCLES = rtcs_pkg::USER_HOLD_CYCLES,
   parameter int SENSE_LEN = rtcs_pkg::SENSE_CYCLES
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [4:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic on_battery,
   input wire logic osc_wave,
   input wire logic osc_fault,
   input wire logic alarm_one_match,
   input wire logic alarm_two_match,
   input wire logic [9:0] temp_sample,
   output logic temp_convert,
   output logic [7:0] cap_trim,
   output logic cap_trim_load,
   output logic osc_enable,
   output logic irq_or_wave_pin_out,
   output logic irq_or_wave_pin_oe,
   output logic low_freq_out,
   output logic low_freq_out_oe
);
   logic [1:0] sync1_q, sync2_q, sync3_q, filt_q, filt_d;
   logic [7:0] ctl_q, ctl_d, aging_q, aging_d, rdata_q, rdata_d;
   logic osf_q, osf_d, en32_q, en32_d, busy_q, busy_d;
   logic a1f_q, a1f_d, a2f_q, a2f_d, convert_request_q, convert_request_d;
   logic [9:0] temp_q, temp_d;
   localparam int DIV_W_L = rtcs_pkg::DIV_W;
   logic [DIV_W_L-1:0] div_q, div_d;
   logic [5:0] sec_q, sec_d;
   logic [rtcs_pkg::TIMER_W-1:0] tmr_q, tmr_d;
   rtcs_pkg::rtcs_state_type st_q, st_d;
   logic user_q, user_d, run_q, run_d, wave_q, wave_d;
   logic load_q, load_d, ioe_q, ioe_d, iout_q, iout_d;
   logic lfo_q, lfo_d, lfoe_q, lfoe_d;
   logic [7:0] trim_q, trim_d;
   logic running, osc_rise, sec_tick, wr_ctl, wr_sta, wr_age, periodic_due;
   logic sel_wave, irq_active;

   // three-stage pin synchronisers; a change counts once stages 2 and 3 agree
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         always_ff @(posedge mclk) begin
            sync1_q[gi] <= (gi == 0) ? on_battery : osc_wave;
            sync2_q[gi] <= sync1_q[gi];
            sync3_q[gi] <= sync2_q[gi];
         end
         assign filt_d[gi] = (sync2_q[gi] == sync3_q[gi]) ?
            sync3_q[gi] : filt_q[gi];
      end
   endgenerate

   assign running = ~(filt_q[0] & ctl_q[rtcs_pkg::CTL_OSC_DIS]);
   assign osc_rise = running & filt_d[1] & ~filt_q[1];
   assign sec_tick = osc_rise & (&div_q);
   assign wr_ctl = reg_wr & (reg_addr == rtcs_pkg::OFS_CONTROL);
   assign wr_sta = reg_wr & (reg_addr == rtcs_pkg::OFS_STATUS);
   assign wr_age = reg_wr & (reg_addr == rtcs_pkg::OFS_AGING);
   assign periodic_due = sec_tick & (sec_q == rtcs_pkg::PERIOD_SECONDS_LAST);

   // register file and flags
   always_comb begin
      ctl_d = ctl_q;
      aging_d = aging_q;
      en32_d = en32_q;
      if (wr_ctl) begin
         // convert bit is hardware owned; a write only requests
         ctl_d = reg_wdata;
         ctl_d[rtcs_pkg::CTL_CONVERT_REQUEST] = 1'b0;
      end
      if (wr_sta) begin
         en32_d = reg_wdata[rtcs_pkg::STA_EN32];
      end
      if (wr_age) begin
         aging_d = reg_wdata;
      end
      osf_d = osf_q;
      if (wr_sta && !reg_wdata[rtcs_pkg::STA_OSF]) begin
         osf_d = 1'b0;
      end
      // stop sets flag, set wins over clear
      if ((run_q & ~running) | osc_fault) begin
         osf_d = 1'b1;
      end
      a1f_d = a1f_q;
      a2f_d = a2f_q;
      // write 0 clears, write 1 keeps
      if (wr_sta) begin
         a1f_d = a1f_q & reg_wdata[rtcs_pkg::STA_A1F];
         a2f_d = a2f_q & reg_wdata[rtcs_pkg::STA_A2F];
      end
      a1f_d = a1f_d | alarm_one_match;
      a2f_d = a2f_d | alarm_two_match;
      run_d = running;
   end

   // divider and periodic schedule
   always_comb begin
      div_d = div_q;
      sec_d = sec_q;
      if (osc_rise) begin
         div_d = div_q + 1'b1;
      end
      // counts seconds regardless of user conversions
      if (sec_tick) begin
         sec_d = sec_q + 1'b1;
      end
   end

   // conversion engine
   always_comb begin
      st_d = st_q;
      tmr_d = tmr_q;
      convert_request_d = convert_request_q;
      busy_d = busy_q;
      user_d = user_q;
      temp_d = temp_q;
      load_d = 1'b0;
      trim_d = trim_q;
      unique case (st_q)
         rtcs_pkg::ST_IDLE: begin
            if (wr_ctl && reg_wdata[rtcs_pkg::CTL_CONVERT_REQUEST]) begin
               st_d = rtcs_pkg::ST_HOLD;
               convert_request_d = 1'b1;
               user_d = 1'b1;
               tmr_d = '0;
            end else if (periodic_due) begin
               st_d = rtcs_pkg::ST_SENSE;
               busy_d = 1'b1;
               user_d = 1'b0;
               tmr_d = '0;
            end
         end
         rtcs_pkg::ST_HOLD: begin
            // busy left alone during the hold
            tmr_d = tmr_q + 1'b1;
            if (tmr_q == rtcs_pkg::TIMER_W'(HOLD_CYCLES - 1)) begin
               st_d = rtcs_pkg::ST_SENSE;
               busy_d = 1'b1;
               tmr_d = '0;
            end
         end
         rtcs_pkg::ST_SENSE: begin
            // frozen while the oscillator is stopped
            if (running) begin
               tmr_d = tmr_q + 1'b1;
            end
            if (running && tmr_q == rtcs_pkg::TIMER_W'(SENSE_LEN - 1)) begin
               st_d = rtcs_pkg::ST_IDLE;
               convert_request_d = 1'b0;
               busy_d = 1'b0;
               temp_d = temp_sample;
               // trim on user run or changed result
               if (user_q || temp_sample != temp_q) begin
                  load_d = 1'b1;
                  trim_d = aging_q;
               end
            end
         end
         default: begin
            st_d = rtcs_pkg::ST_IDLE;
         end
      endcase
   end

   // pins and readback
   always_comb begin
      unique case (ctl_q[rtcs_pkg::CTL_RS_HI:rtcs_pkg::CTL_RS_LO])
         2'b00: wave_d = div_q[rtcs_pkg::TAP_1HZ];
         2'b01: wave_d = div_q[rtcs_pkg::TAP_1K];
         2'b10: wave_d = div_q[rtcs_pkg::TAP_4K];
         2'b11: wave_d = div_q[rtcs_pkg::TAP_8K];
      endcase
      // flag needs its enable and select
      irq_active = ctl_q[rtcs_pkg::CTL_IRQ_SEL] &
         ((a1f_q & ctl_q[rtcs_pkg::CTL_ALARM_ONE_IRQ_ENABLE]) |
          (a2f_q & ctl_q[rtcs_pkg::CTL_ALARM_TWO_IRQ_ENABLE]));
      // backup supply needs the backup enable
      sel_wave = ~ctl_q[rtcs_pkg::CTL_IRQ_SEL] &
         (~filt_q[0] | ctl_q[rtcs_pkg::CTL_BACKUP_SQUARE_WAVE_ENABLE]);
      // pulled low while an enabled flag stays set
      ioe_d = sel_wave | irq_active;
      iout_d = sel_wave ? wave_q : 1'b0;
      // 32 kHz pin only while enabled and running
      lfoe_d = en32_q & running;
      lfo_d = filt_q[1] & running;
      unique case (reg_addr)
         rtcs_pkg::OFS_CONTROL: begin
            rdata_d = ctl_q;
            rdata_d[rtcs_pkg::CTL_CONVERT_REQUEST] = convert_request_q;
         end
         rtcs_pkg::OFS_STATUS: begin
            rdata_d = 8'h00;
            rdata_d[rtcs_pkg::STA_OSF] = osf_q;
            rdata_d[rtcs_pkg::STA_EN32] = en32_q;
            rdata_d[rtcs_pkg::STA_BUSY] = busy_q;
            rdata_d[rtcs_pkg::STA_A2F] = a2f_q;
            rdata_d[rtcs_pkg::STA_A1F] = a1f_q;
         end
         rtcs_pkg::OFS_AGING: rdata_d = aging_q;
         // integer byte, then fraction in bits 7:6
         rtcs_pkg::OFS_TEMP_HI: rdata_d = temp_q[9:2];
         rtcs_pkg::OFS_TEMP_LO: rdata_d = {temp_q[1:0], 6'h00};
         default: rdata_d = 8'h00;
      endcase
   end

   // state registers; power-up starts in a conversion
   always_ff @(posedge mclk) begin
      if (srst) begin
         filt_q <= 2'h0;
         ctl_q <= rtcs_pkg::CONTROL_RESET;
         aging_q <= rtcs_pkg::AGING_RESET;
         osf_q <= rtcs_pkg::OSF_RESET;
         en32_q <= rtcs_pkg::EN32_RESET;
         a1f_q <= 1'b0;
         a2f_q <= 1'b0;
         run_q <= 1'b1;
         div_q <= '0;
         sec_q <= 6'h00;
         st_q <= rtcs_pkg::ST_SENSE;
         tmr_q <= '0;
         convert_request_q <= 1'b0;
         busy_q <= 1'b1;
         user_q <= 1'b0;
         temp_q <= rtcs_pkg::TEMP_RESET;
         load_q <= 1'b0;
         trim_q <= rtcs_pkg::AGING_RESET;
         wave_q <= 1'b0;
         ioe_q <= 1'b0;
         iout_q <= 1'b0;
         lfo_q <= 1'b0;
         lfoe_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         filt_q <= filt_d;
         ctl_q <= ctl_d;
         aging_q <= aging_d;
         osf_q <= osf_d;
         en32_q <= en32_d;
         a1f_q <= a1f_d;
         a2f_q <= a2f_d;
         run_q <= run_d;
         div_q <= div_d;
         sec_q <= sec_d;
         st_q <= st_d;
         tmr_q <= tmr_d;
         convert_request_q <= convert_request_d;
         busy_q <= busy_d;
         user_q <= user_d;
         temp_q <= temp_d;
         load_q <= load_d;
         trim_q <= trim_d;
         wave_q <= wave_d;
         ioe_q <= ioe_d;
         iout_q <= iout_d;
         lfo_q <= lfo_d;
         lfoe_q <= lfoe_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign temp_convert = busy_q;
   assign cap_trim = trim_q;
   assign cap_trim_load = load_q;
   assign osc_enable = run_q;
   assign irq_or_wave_pin_out = iout_q;
   assign irq_or_wave_pin_oe = ioe_q;
   assign low_freq_out = lfo_q;
   assign low_freq_out_oe = lfoe_q;
endmodule // rtcs_regs
`default_nettype wire

// file: logic/rtcs_pkg.sv
package rtcs_pkg;
   // register offsets on the register port
   localparam logic [4:0] OFS_CONTROL = 5'h0e;
   localparam logic [4:0] OFS_STATUS = 5'h0f;
   localparam logic [4:0] OFS_AGING = 5'h10;
   localparam logic [4:0] OFS_TEMP_HI = 5'h11;
   localparam logic [4:0] OFS_TEMP_LO = 5'h12;
   // clock_control fields
   localparam int CTL_OSC_DIS = 7;
   localparam int CTL_BACKUP_SQUARE_WAVE_ENABLE = 6;
   localparam int CTL_CONVERT_REQUEST = 5;
   localparam int CTL_RS_HI = 4;
   localparam int CTL_RS_LO = 3;
   localparam int CTL_IRQ_SEL = 2;
   localparam int CTL_ALARM_TWO_IRQ_ENABLE = 1;
   localparam int CTL_ALARM_ONE_IRQ_ENABLE = 0;
   // clock_status fields
   localparam int STA_OSF = 7;
   localparam int STA_EN32 = 3;
   localparam int STA_BUSY = 2;
   localparam int STA_A2F = 1;
   localparam int STA_A1F = 0;
   // values after reset
   localparam logic [7:0] CONTROL_RESET = 8'h1c;
   localparam logic [7:0] AGING_RESET = 8'h00;
   localparam logic [9:0] TEMP_RESET = 10'h000;
   localparam logic OSF_RESET = 1'b1;
   localparam logic EN32_RESET = 1'b1;
   // divider taps for each rate select code (1 Hz, 1024, 4096, 8192 Hz)
   localparam int TAP_1HZ = 14;
   localparam int TAP_1K = 4;
   localparam int TAP_4K = 2;
   localparam int TAP_8K = 1;
   localparam int DIV_W = 15;
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int USER_HOLD_NS = 2000000;
   localparam int USER_HOLD_CYCLES = USER_HOLD_NS / CLK_PERIOD_NS;
   localparam int SENSE_NS = 2000000;
   localparam int SENSE_CYCLES = SENSE_NS / CLK_PERIOD_NS;
   localparam logic [5:0] PERIOD_SECONDS_LAST = 6'h3f; // 64 s schedule
   localparam int TIMER_W = 20;
   // conversion engine states, gray along idle, hold, sense
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HOLD = 2'b01,
      ST_SENSE = 2'b11
   } rtcs_state_type;
endpackage

// file: testbench/rtcs_host.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the register port, standing in for the serial slave
module rtcs_host (
   input wire logic mclk,
   output logic [4:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata
);
   logic [15:0] exp_q[$]; // {expected, mask} per read
   logic chk = 1'b0;
   initial begin
      reg_addr = 5'h1f;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end
   // one-cycle strobe; data inverted after so a stale latch shows
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wr <= 1'b1;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   // address held two edges before the answer is flagged
   task automatic rd(input logic [4:0] a, input logic [7:0] e,
      input logic [7:0] m);
      @(posedge mclk);
      reg_addr <= a;
      exp_q.push_back({e, m});
      repeat (2) @(posedge mclk);
      chk <= 1'b1;
      @(posedge mclk);
      chk <= 1'b0;
   endtask
endmodule // rtcs_host
`default_nettype wire

// file: testbench/rtcs_regs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// port-level checks of the control and status behaviour
module rtcs_regs_monitor (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [4:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic on_battery,
   input wire logic alarm_one_match,
   input wire logic [7:0] cap_trim,
   input wire logic cap_trim_load,
   input wire logic osc_enable,
   input wire logic irq_or_wave_pin_out,
   input wire logic irq_or_wave_pin_oe,
   input wire logic low_freq_out_oe
);
   logic [7:0] ctl_q, ctl_d, trim_q, trim_d;
   logic en32_q, en32_d;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (srst);
   // shadow of the writable fields, since the design copy is hidden
   always_comb begin
      ctl_d = ctl_q;
      trim_d = trim_q;
      en32_d = en32_q;
      if (reg_wr && reg_addr == 5'h0e) ctl_d = reg_wdata;
      if (reg_wr && reg_addr == 5'h10) trim_d = reg_wdata;
      if (reg_wr && reg_addr == 5'h0f) en32_d = reg_wdata[3];
      if (srst) begin
         ctl_d = rtcs_pkg::CONTROL_RESET;
         trim_d = 8'h00;
         en32_d = 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      ctl_q <= ctl_d;
      trim_q <= trim_d;
      en32_q <= en32_d;
   end
   osc_on_mains_a: assert property (!on_battery [*6] |-> osc_enable)
      else $error("oscillator stopped on main supply");
   wave_hiz_a: assert property (
      (on_battery && !ctl_q[6] && !ctl_q[2]) [*6] |-> !irq_or_wave_pin_oe)
      else $error("shared pin driven on backup without enable");
   ctl_readback_a: assert property (
      (reg_addr == 5'h0e && !reg_wr) [*2] |->
      ##1 (reg_rdata & 8'hdf) == (ctl_q & 8'hdf))
      else $error("control readback differs from last write");
   temp_low_pad_a: assert property (
      (reg_addr == 5'h12) [*2] |-> ##1 reg_rdata[5:0] == 6'h00)
      else $error("temperature low byte padding not zero");
   irq_assert_a: assert property (
      alarm_one_match && !reg_wr && ctl_q[2] && ctl_q[0] ##1 !reg_wr
      |-> ##1 irq_or_wave_pin_oe && !irq_or_wave_pin_out)
      else $error("enabled alarm did not assert the pin");
   irq_gated_a: assert property (
      (ctl_q[2] && ctl_q[1:0] == 2'b00) [*3]
      |-> !(irq_or_wave_pin_oe && !irq_or_wave_pin_out))
      else $error("pin asserted with both alarm enables clear");
   trim_value_a: assert property (cap_trim_load |-> cap_trim == trim_q)
      else $error("applied trim differs from aging register");
   lf_hiz_a: assert property (!en32_q [*3] |-> !low_freq_out_oe)
      else $error("32 kHz pin driven while disabled");
endmodule // rtcs_regs_monitor
bind rtcs_regs rtcs_regs_monitor rtcs_regs_monitor_i (.*);
`default_nettype wire

// file: testbench/test_rtcs_regs.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) \
   n_compared++; \
   if ((g) !== (e)) begin \
      err_count++; \
      $display("ERROR %s expected %h seen %h", n, e, g); \
   end
module test_rtcs_regs;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic on_battery = 1'b0;
   logic osc_wave = 1'b0;
   logic osc_fault = 1'b0;
   logic alarm_one_match = 1'b0;
   logic alarm_two_match = 1'b0;
   logic [9:0] temp_sample = 10'h065;
   logic [4:0] reg_addr;
   logic reg_wr;
   logic [7:0] reg_wdata, reg_rdata, cap_trim, aging, note_m;
   logic temp_convert, cap_trim_load, osc_enable, lf_out, lf_oe;
   logic pin_out, pin_oe;
   logic [15:0] note;
   logic [4:0] ra[7] = '{5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h00};
   logic [7:0] re[7] = '{8'h1c, 8'h88, 8'h00, 8'h19, 8'h40, 8'h00, 8'h00};
   int err_count = 0;
   int n_compared = 0;
   int unsigned seed;
   int osc_rises = 0;
   int r0;
   rtcs_regs #(.HOLD_CYCLES(8), .SENSE_LEN(8)) rtcs_regs_i (.mclk, .srst,
      .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .on_battery, .osc_wave,
      .osc_fault, .alarm_one_match, .alarm_two_match, .temp_sample,
      .temp_convert, .cap_trim, .cap_trim_load, .osc_enable,
      .irq_or_wave_pin_out(pin_out), .irq_or_wave_pin_oe(pin_oe),
      .low_freq_out(lf_out), .low_freq_out_oe(lf_oe));
   rtcs_host rtcs_host_i (.mclk, .reg_addr, .reg_wr, .reg_wdata);
   // crystal runs unrelated in phase to the system clock
   always #(rtcs_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;
   always #83 osc_wave = ~osc_wave;
   // crystal edges as the yardstick for the pin frequencies
   always @(posedge osc_wave) osc_rises++;
   // compare each flagged read with the oldest note
   always @(negedge mclk) begin
      if (rtcs_host_i.chk === 1'b1) begin
         note = rtcs_host_i.exp_q.pop_front();
         note_m = note[7:0];
         `CHK("read", note[15:8] & note_m, reg_rdata & note_m)
      end
   end
   // interrupt seen as open-drain low
   task automatic irq(input logic e);
      repeat (3) @(negedge mclk);
      `CHK("irq pin", e, pin_oe & ~pin_out)
   endtask
   // half period of the shared pin counted in crystal rises;
   // the first rising edge may still belong to the old rate
   task automatic wave(input logic [1:0] rs, input int e);
      rtcs_host_i.wr(5'h0e, {3'h0, rs, 3'h0});
      @(posedge pin_out);
      @(posedge pin_out);
      r0 = osc_rises;
      @(negedge pin_out);
      `CHK("wave half period", e, osc_rises - r0)
   endtask
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // cut a hang short well beyond the expected run
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      end_sim;
   end
   initial begin
      seed = $urandom(95);
      repeat (6) @(posedge mclk);
      srst <= 1'b0;
      repeat (24) @(posedge mclk);
      for (int i = 0; i < 7; i++) begin
         rtcs_host_i.rd(ra[i], re[i], i == 1 ? 8'hfc : 8'hff);
      end
      rtcs_host_i.wr(5'h0f, 8'hff);
      rtcs_host_i.rd(5'h0f, 8'h88, 8'hfb);
      rtcs_host_i.wr(5'h0f, 8'h00);
      rtcs_host_i.rd(5'h0f, 8'h00, 8'hfb);
      @(negedge mclk);
      `CHK("32k released", 1'b0, lf_oe)
      @(posedge mclk) osc_fault <= 1'b1;
      @(posedge mclk) osc_fault <= 1'b0;
      rtcs_host_i.rd(5'h0f, 8'h80, 8'hfb);
      rtcs_host_i.wr(5'h0f, 8'h08);
      rtcs_host_i.wr(5'h0e, 8'h05);
      @(posedge mclk) alarm_two_match <= 1'b1;
      @(posedge mclk) alarm_two_match <= 1'b0;
      rtcs_host_i.rd(5'h0f, 8'h0a, 8'hfb);
      irq(1'b0);
      `CHK("32k driven", 1'b1, lf_oe)
      // one pin rise for every crystal rise
      @(posedge lf_out) r0 = osc_rises;
      @(posedge lf_out);
      `CHK("32k period", 1, osc_rises - r0)
      @(posedge mclk) alarm_one_match <= 1'b1;
      @(posedge mclk) alarm_one_match <= 1'b0;
      irq(1'b1);
      rtcs_host_i.wr(5'h0f, 8'h09);
      irq(1'b1);
      rtcs_host_i.wr(5'h0f, 8'h08);
      irq(1'b0);
      aging = 8'($urandom);
      @(posedge mclk) temp_sample <= 10'($urandom);
      rtcs_host_i.wr(5'h10, aging);
      rtcs_host_i.wr(5'h0e, 8'h25);
      @(negedge mclk);
      `CHK("busy in hold", 1'b0, temp_convert)
      rtcs_host_i.rd(5'h0e, 8'h25, 8'hff);
      // hold of 8 cycles is over, sensing of 8 cycles under way
      repeat (6) @(negedge mclk);
      `CHK("busy in sense", 1'b1, temp_convert)
      for (int n = 0; n < 40 && cap_trim_load !== 1'b1; n++) begin
         @(negedge mclk);
      end
      `CHK("trim load", 1'b1, cap_trim_load)
      `CHK("trim", aging, cap_trim)
      rtcs_host_i.rd(5'h0e, 8'h05, 8'hff);
      rtcs_host_i.rd(5'h0f, 8'h08, 8'hff);
      rtcs_host_i.rd(5'h11, temp_sample[9:2], 8'hff);
      rtcs_host_i.rd(5'h12, {temp_sample[1:0], 6'h00}, 8'hff);
      rtcs_host_i.wr(5'h0e, 8'h80);
      @(posedge mclk) on_battery <= 1'b1;
      repeat (8) @(negedge mclk);
      `CHK("osc on backup", 1'b0, osc_enable)
      `CHK("pin released", 1'b0, pin_oe)
      rtcs_host_i.wr(5'h0e, 8'h40);
      repeat (8) @(negedge mclk);
      `CHK("backup wave", 1'b1, pin_oe)
      @(posedge mclk) on_battery <= 1'b0;
      repeat (8) @(negedge mclk);
      `CHK("osc on mains", 1'b1, osc_enable)
      // 32768 Hz over twice the selected rate
      wave(2'b01, 16);
      wave(2'b10, 4);
      wave(2'b11, 2);
      rtcs_host_i.rd(5'h0f, 8'h80, 8'h80);
      end_sim;
   end
endmodule // test_rtcs_regs
`default_nettype wire
